// ===== core/lk_core.sv
// reference oscillator, digital pll and dual phase-sensitive detector
`timescale 1ns/10ps
`include "lk_regs.svh"
module lk_core
   import lk_pkg::*;
#(
   parameter int HARM_MAX = 99
) (
   input  wire logic        core_clk_in,
   input  wire logic        rst_in,
   input  wire logic [4:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   input  wire logic        ref_pin_in,
   input  wire lk_adc_t     adc_in,
   output logic signed [15:0] sine_out,
   output logic             sync_out,
   output lk_psd_t          psd_out
);
   generate
      if (HARM_MAX < 1 || HARM_MAX > 127) begin : g_bad_harm
         $error("HARM_MAX must lie in 1..127");
      end
   endgenerate

   localparam logic [6:0] HARM_TOP = 7'(HARM_MAX);

   // sine by two parabolic half cycles; cheap, no table storage
   function automatic logic signed [15:0] sine_of(input logic [31:0] ph);
      logic [29:0] u;
      logic [29:0] p;
      logic [16:0] m;
      logic [14:0] mag;
      u = {15'h0, ph[30:16]};
      p = 30'(u * (`LK_SIN_HALF - u));
      m = p[29:13];
      mag = (m > `LK_SIN_MAX) ? 15'h7FFF : m[14:0];
      return ph[31] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
   endfunction

   // bus slave: one wait state per access
   logic        ack_q;
   logic        req;
   logic        wr_en;
   logic [31:0] readdata_q;
   assign req = avs_read_in | avs_write_in;
   assign avs_waitrequest_out = req & ~ack_q;
   assign wr_en = avs_write_in & ack_q &
                  (avs_byteenable_in == `LK_FULL_BE);
   assign avs_readdata_out = readdata_q;

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   // control registers
   logic        ext_q;
   lk_trig_t    trig_q;
   logic [31:0] freq_q;
   logic [18:0] mdeg_q;
   logic [6:0]  harm_q;
   logic [31:0] pll_inc_q;
   logic        locked_q;
   logic        armed_q;
   logic [31:0] eff_inc;
   logic [38:0] harm_chk;

   assign eff_inc = ext_q ? pll_inc_q : freq_q;
   assign harm_chk = 39'(avs_writedata_in[6:0]) * 39'(eff_inc);

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ext_q  <= 1'b0;
         trig_q <= LK_TRIG_SINE;
         freq_q <= `LK_RST_FREQ;
         mdeg_q <= '0;
         harm_q <= `LK_RST_HARM;
      end else if (wr_en) begin
         unique case (avs_address_in)
            `LK_OFF_CTRL: begin
               ext_q <= avs_writedata_in[`LK_CTRL_EXT];
               if (avs_writedata_in[`LK_CTRL_TRIG_HI:`LK_CTRL_TRIG_LO]
                   != 2'b11) begin
                  trig_q <= lk_trig_t'(avs_writedata_in
                            [`LK_CTRL_TRIG_HI:`LK_CTRL_TRIG_LO]);
               end
            end
            `LK_OFF_FREQ: begin
               if (avs_writedata_in <= `LK_MAX_INC) begin
                  freq_q <= avs_writedata_in;
               end
            end
            `LK_OFF_PHASE: begin
               if (avs_writedata_in <= 32'(`LK_MDEG_MAX)) begin
                  mdeg_q <= avs_writedata_in[18:0];
               end
            end
            `LK_OFF_HARM: begin
               if (avs_writedata_in[31:7] == '0 &&
                   avs_writedata_in[6:0] != 7'h00 &&
                   avs_writedata_in[6:0] <= HARM_TOP &&
                   harm_chk <= 39'(`LK_MAX_INC)) begin
                  harm_q <= avs_writedata_in[6:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         readdata_q <= '0;
      end else if (avs_read_in & ~ack_q) begin
         unique case (avs_address_in)
            `LK_OFF_CTRL:   readdata_q <= {29'h0, trig_q, ext_q};
            `LK_OFF_FREQ:   readdata_q <= freq_q;
            `LK_OFF_PHASE:  readdata_q <= {13'h0, mdeg_q};
            `LK_OFF_HARM:   readdata_q <= {25'h0, harm_q};
            `LK_OFF_STATUS: readdata_q <= {30'h0, ext_q, locked_q};
            `LK_OFF_PLLINC: readdata_q <= pll_inc_q;
            default:        readdata_q <= '0;
         endcase
      end
   end

   // reference pin synchroniser, then edge detect on the second stage
   logic ref_s1_q;
   logic ref_s2_q;
   logic ref_s3_q;
   logic rise;
   logic fall;
   logic trig_evt;

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ref_s1_q <= 1'b0;
         ref_s2_q <= 1'b0;
         ref_s3_q <= 1'b0;
      end else begin
         ref_s1_q <= ref_pin_in;
         ref_s2_q <= ref_s1_q;
         ref_s3_q <= ref_s2_q;
      end
   end

   assign rise = ref_s2_q & ~ref_s3_q;
   assign fall = ~ref_s2_q & ref_s3_q;
   // sine mode sees the comparator output; its rise is the + crossing
   assign trig_evt = ext_q & ((trig_q == LK_TRIG_FALL) ? fall : rise);

   // oscillator phase accumulator, advanced once per adc sample
   logic [31:0]        acc_q;
   logic signed [31:0] err;
   assign err = $signed(acc_q);

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         acc_q <= '0;
      end else if (trig_evt) begin
         acc_q <= '0;
      end else if (adc_in.valid) begin
         acc_q <= acc_q + eff_inc;
      end
   end

   // loop: phase error at each edge after the first trims the increment
   // hard zero at the edge costs a little jitter, internal mode has none
   logic signed [31:0] pll_step;
   logic signed [32:0] pll_next;
   assign pll_step = err >>> `LK_PLL_SHIFT;
   assign pll_next = $signed({1'b0, pll_inc_q}) - 33'(pll_step);

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pll_inc_q <= `LK_RST_FREQ;
         locked_q  <= 1'b0;
         armed_q   <= 1'b0;
      end else if (trig_evt) begin
         armed_q <= 1'b1;
         // first edge after entry only aligns phase
         // its error says nothing about the rate, so no trim
         if (armed_q && pll_next < 0) begin
            pll_inc_q <= '0;
         end else if (armed_q &&
                      pll_next > $signed({1'b0, `LK_MAX_INC})) begin
            pll_inc_q <= `LK_MAX_INC;
         end else if (armed_q) begin
            pll_inc_q <= pll_next[31:0];
         end
         locked_q <= armed_q &&
                     (err < $signed(`LK_LOCK_TOL)) &&
                     (err > -$signed(`LK_LOCK_TOL));
      end else if (!ext_q) begin
         // loop rests on the programmed rate so entry starts near lock
         pll_inc_q <= freq_q;
         armed_q   <= 1'b0;
         locked_q  <= 1'b0;
      end
   end

   // detector references: scaled phase plus rounded offset words
   logic [48:0] off_prod;
   logic [31:0] off_word;
   logic [31:0] harm_ph;
   logic [31:0] ref_ph [2];
   logic signed [15:0] ref_sin [2];

   // round to nearest, so 90 degrees gives exactly a quarter turn
   assign off_prod = 49'(mdeg_q) * 49'(`LK_MDEG_K) + `LK_MDEG_RND;
   assign off_word = off_prod[47:16];
   assign harm_ph = 32'(acc_q * harm_q);
   assign ref_ph[0] = harm_ph + off_word;
   assign ref_ph[1] = harm_ph + off_word + `LK_QUARTER;

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_ref
         assign ref_sin[ch] = sine_of(ref_ph[ch]);
      end
   endgenerate

   // oscillator outputs stay at the fundamental
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sine_out <= '0;
         sync_out <= 1'b0;
      end else begin
         sine_out <= sine_of(acc_q);
         sync_out <= ~acc_q[31];
      end
   end

   // products: one multiply per sample per channel
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         psd_out <= '0;
      end else begin
         psd_out.valid <= adc_in.valid;
         if (adc_in.valid) begin
            psd_out.x <= adc_in.data * ref_sin[0];
            psd_out.y <= adc_in.data * ref_sin[1];
         end
      end
   end

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);

   AST_EDGE_ZERO: assert property (trig_evt |=> acc_q == '0)
      else $error("accumulator not zero after reference edge");
   AST_TRIG_POL: assert property (trig_evt |-> ext_q &&
      ((trig_q == LK_TRIG_FALL) ? (!ref_s2_q && ref_s3_q)
                                : (ref_s2_q && !ref_s3_q)))
      else $error("trigger on wrong edge polarity");
   AST_INT_BYPASS: assert property (!ext_q |=>
      pll_inc_q == $past(freq_q))
      else $error("loop moved in internal mode");
   AST_SYNC_HI: assert property (sine_out > 0 |-> sync_out)
      else $error("sync low while sine positive");
   AST_SYNC_LO: assert property (sine_out < 0 |-> !sync_out)
      else $error("sync high while sine negative");
   AST_QUAD: assert property (ref_ph[1] - ref_ph[0] == `LK_QUARTER)
      else $error("quadrature offset not a quarter turn");
   AST_OFFSET: assert property (ref_ph[0] - harm_ph == off_word)
      else $error("in-phase offset missing");
   AST_HARM_RANGE: assert property (harm_q != 7'h00 &&
                                    harm_q <= HARM_TOP)
      else $error("harmonic outside range");
   AST_ADVANCE: assert property (adc_in.valid && !trig_evt |=>
      acc_q == $past(acc_q) + $past(eff_inc))
      else $error("accumulator did not advance by increment");
   AST_PSD_X: assert property (adc_in.valid |=> psd_out.valid &&
      psd_out.x == $past(adc_in.data) * $past(ref_sin[0]))
      else $error("x product wrong or missing");
   AST_PSD_PULSE: assert property (!adc_in.valid |=> !psd_out.valid)
      else $error("valid without a sample");
   AST_WAIT: assert property (req && !ack_q |-> avs_waitrequest_out
                              ##1 !avs_waitrequest_out)
      else $error("bus answer not after one wait state");
   AST_ACK_GO: assert property (ack_q |-> !avs_waitrequest_out)
      else $error("waitrequest high on answer cycle");
   AST_RD_STABLE: assert property (!req |=> $stable(avs_readdata_out))
      else $error("read data moved without a request");
   AST_WR_REFUSE: assert property (avs_write_in &&
      avs_byteenable_in != `LK_FULL_BE |=> $stable(freq_q) &&
      $stable(mdeg_q) && $stable(harm_q))
      else $error("partial write changed a register");
   AST_MDEG_RANGE: assert property (mdeg_q <= `LK_MDEG_MAX)
      else $error("phase offset outside range");

   // reference and loop checks
   AST_NO_EXT_TRIG: assert property (!ext_q |-> !trig_evt)
      else $error("reference edge used in internal mode");
   AST_TRIG_REF: assert property (trig_evt &&
      trig_q != LK_TRIG_FALL |-> $rose(ref_s2_q))
      else $error("rising trigger without a rising reference");
   AST_FIRST_ALIGN: assert property (trig_evt && !armed_q |=>
      $stable(pll_inc_q))
      else $error("loop trimmed on the aligning edge");
   AST_LOCK_INT: assert property (!ext_q |=> !locked_q)
      else $error("locked flag set in internal mode");
   AST_FREQ_MAX: assert property (freq_q <= `LK_MAX_INC &&
      pll_inc_q <= `LK_MAX_INC)
      else $error("increment above the top rate");
   AST_ACC_HOLD: assert property (!adc_in.valid && !trig_evt |=>
      $stable(acc_q))
      else $error("accumulator moved without a sample");

   // oscillator output and detector checks
   AST_SINE_FUND: assert property (1'b1 |=>
      sine_out == $past(sine_of(acc_q)))
      else $error("sine output not at the fundamental");
   AST_PSD_Y: assert property (adc_in.valid |=> psd_out.valid &&
      psd_out.y == $past(adc_in.data) * $past(ref_sin[1]))
      else $error("y product wrong or missing");
   AST_PSD_HOLD: assert property (!adc_in.valid |=>
      $stable(psd_out.x) && $stable(psd_out.y))
      else $error("products moved without a sample");
endmodule

// ===== core/lk_pkg.sv
// types shared by the lock-in reference and detector core
package lk_pkg;
   typedef enum logic [1:0] {
      LK_TRIG_SINE = 2'b00,
      LK_TRIG_RISE = 2'b01,
      LK_TRIG_FALL = 2'b10
   } lk_trig_t;
   typedef struct packed {
      logic                valid;
      logic signed [31:0] x;
      logic signed [31:0] y;
   } lk_psd_t;
   typedef struct packed {
      logic               valid;
      logic signed [15:0] data;
   } lk_adc_t;
endpackage

// ===== core/lk_regs.svh
// register map, field positions, reset values and limits of the lock-in core
`ifndef LK_REGS_SVH
`define LK_REGS_SVH
`define LK_OFF_CTRL      5'h00
`define LK_OFF_FREQ      5'h04
`define LK_OFF_PHASE     5'h08
`define LK_OFF_HARM      5'h0C
`define LK_OFF_STATUS    5'h10
`define LK_OFF_PLLINC    5'h14
`define LK_CTRL_EXT      0
`define LK_CTRL_TRIG_LO  1
`define LK_CTRL_TRIG_HI  2
`define LK_RST_FREQ      32'h0006_8DB9
`define LK_RST_HARM      7'h01
`define LK_FULL_BE       4'hF
`define LK_SAMPLE_HZ     10000000
`define LK_FMAX_HZ       500000
`define LK_MAX_INC       32'h0CCC_CCCC
`define LK_MDEG_MAX      19'h57E3F
`define LK_MDEG_K        30'h2E9A_76F7
`define LK_MDEG_RND      49'h0_0000_0000_8000
`define LK_QUARTER       32'h4000_0000
`define LK_PLL_SHIFT    6
`define LK_LOCK_TOL      32'h0100_0000
`define LK_SIN_HALF      30'h0000_8000
`define LK_SIN_MAX       17'h07FFF
`endif

// ===== verification/lk_src_model.sv
// reference square source and sample feed for the lock-in core
`timescale 1ns/10ps
module lk_src_model
   import lk_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        ref_en_in,
   input  wire logic        adc_en_in,
   input  wire logic [15:0] data_in,
   output logic             ref_pin_out,
   output lk_adc_t          adc_out,
   output logic [5:0]       idx_out
);
   int   cnt = 0;
   int   gap = 0;
   logic ph  = 1'b0;
   initial adc_out = '0;
   initial ref_pin_out = 1'b0;
   // logic level 10 kHz square, parked low between runs
   always @(posedge clk_in) begin
      cnt <= (ref_en_in && cnt < 1249) ? cnt + 1 : 0;
      if (!ref_en_in)
         ref_pin_out <= 1'b0;
      else if (cnt == 1249)
         ref_pin_out <= ~ref_pin_out;
   end
   // gaps of 2 and 3 cycles give 10 MHz; idle data toggles, never stale
   always @(posedge clk_in) begin
      adc_out.valid <= adc_en_in && !rst_in && gap == 0;
      adc_out.data  <= ~adc_out.data;
      if (rst_in || !adc_en_in) begin
         gap     <= 0;
         ph      <= 1'b0;
         idx_out <= '0;
      end else if (gap == 0) begin
         adc_out.data <= data_in;
         idx_out      <= idx_out + 6'h01;
         gap          <= ph ? 2 : 1;
         ph           <= ~ph;
      end else
         gap <= gap - 1;
   end
endmodule

// ===== verification/tb_top.sv
// self-checking bench for the lock-in reference and detector core
`timescale 1ns/10ps
`include "lk_regs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
$display("Error %0t: got %h want %h", $time, a, b); end end
module tb_top
   import lk_pkg::*;
;
   localparam int NS = 48;
   logic               clk = 1'b0;
   logic               rst = 1'b1;
   logic [4:0]         av_a = '0;
   logic               av_r = 1'b0;
   logic               av_w = 1'b0;
   logic [31:0]        av_d = '0;
   logic [3:0]         av_be = '0;
   logic               ref_en = 1'b0;
   logic               adc_en = 1'b0;
   logic               cap = 1'b0;
   logic [31:0]        rdata, rd;
   logic               wreq, ref_pin, sync, vq;
   logic signed [15:0] sine;
   logic [5:0]         idx;
   logic [15:0]        d_tab[64];
   logic [31:0]        m[32];
   lk_adc_t            adc;
   lk_psd_t            psd;
   logic signed [31:0] xs[4][NS], ys[4][NS];
   logic signed [15:0] ss[4][NS];
   logic               sy[4][NS];
   int                 fails = 0, tests_run = 0, cyc = 0, k = 0, run = 0;
   lk_trig_t           tm[3] = '{LK_TRIG_SINE, LK_TRIG_RISE, LK_TRIG_FALL};
   logic [4:0]         wa[12] = '{5'h04, 5'h04, 5'h0C, 5'h04, 5'h0C, 5'h0C,
                                  5'h04, 5'h0C, 5'h0C, 5'h08, 5'h08, 5'h08};
   logic [31:0]        wd[12] = '{32'h0CCC_CCCD, 32'h0CCC_CCCC, 32'h2,
                                  32'h0333_3333, 32'h4, 32'h5, 32'h0006_8DB9,
                                  32'd99, 32'd100, 32'h0005_7E3F,
                                  32'h0005_7E40, 32'h1};
   lk_core #(.HARM_MAX(99)) uut (
      .core_clk_in         (clk),
      .rst_in              (rst),
      .avs_address_in      (av_a),
      .avs_read_in         (av_r),
      .avs_write_in        (av_w),
      .avs_writedata_in    (av_d),
      .avs_byteenable_in   (av_be),
      .avs_readdata_out    (rdata),
      .avs_waitrequest_out (wreq),
      .ref_pin_in          (ref_pin),
      .adc_in              (adc),
      .sine_out            (sine),
      .sync_out            (sync),
      .psd_out             (psd)
   );
   lk_src_model src (
      .clk_in      (clk),
      .rst_in      (rst),
      .ref_en_in   (ref_en),
      .adc_en_in   (adc_en),
      .data_in     (d_tab[idx]),
      .ref_pin_out (ref_pin),
      .adc_out     (adc),
      .idx_out     (idx)
   );
   initial begin
      forever #20 clk = ~clk;
   end
   // whole run needs about 17000 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fails++;
         wrap_up();
      end
   end
   always @(posedge clk) begin
      if (!rst) `CHK(psd.valid, vq)
      vq <= !rst && adc.valid;
      if (cap && psd.valid && k < NS) begin
         xs[run][k] <= psd.x;
         ys[run][k] <= psd.y;
         ss[run][k] <= sine;
         sy[run][k] <= sync;
         k <= k + 1;
      end
   end
   function automatic logic ok_wr(input logic [4:0] a, input logic [31:0] v,
                                  input logic [31:0] fq);
      case (a)
         `LK_OFF_FREQ:  return v <= `LK_MAX_INC;
         `LK_OFF_PHASE: return v <= 32'(`LK_MDEG_MAX);
         `LK_OFF_HARM:  return v >= 1 && v <= 99 && 64'(v) * fq <= 64'(`LK_MAX_INC);
         default:       return 1'b0;
      endcase
   endfunction
   // offset word rounding may cost up to two lsb of the reference sine
   function automatic logic near(input logic signed [31:0] a, b,
                                 input logic signed [15:0] d);
      logic signed [33:0] e, lim;
      e = a - b;
      lim = (d < 0) ? -2 * d : 2 * d;
      return e <= lim && e >= -lim;
   endfunction
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic do_reset();
      rst <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
      int n;
      n = 0;
      av_a <= a;
      av_w <= wr;
      av_r <= !wr;
      av_d <= d;
      av_be <= be;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 20);
      if (n == 20) fails++;
      q = rdata;
      av_w <= 1'b0;
      av_r <= 1'b0;
      @(posedge clk);
   endtask
   task automatic run_int(input int r, input logic [31:0] ph, hm, fq);
      int n;
      do_reset();
      bus(1'b1, `LK_OFF_PHASE, ph, 4'hF, rd);
      bus(1'b1, `LK_OFF_HARM, hm, 4'hF, rd);
      bus(1'b1, `LK_OFF_FREQ, fq, 4'hF, rd);
      n = 0;
      run = r;
      k = 0;
      cap = 1'b1;
      adc_en <= 1'b1;
      while (k < NS && n < 400) begin
         @(posedge clk);
         n++;
      end
      adc_en <= 1'b0;
      cap = 1'b0;
   endtask
   task automatic wait_edge(input logic fall);
      logic p;
      int   n;
      n = 0;
      do begin
         p = ref_pin;
         @(posedge clk);
         n++;
      end while (!(p === fall && ref_pin === !fall) && n < 4000);
      if (n == 4000) fails++;
   endtask
   initial begin
      void'($urandom(76));
      foreach (d_tab[i]) d_tab[i] = 16'($urandom);
      d_tab[0] = 16'h8000;
      d_tab[1] = 16'h7FFF;
      m = '{default: '0};
      m[4] = `LK_RST_FREQ;
      m[12] = 32'h1;
      m[20] = `LK_RST_FREQ;
      do_reset();
      for (int a = 0; a < 28; a += 4) begin
         if (a != 16) bus(1'b0, 5'(a), '0, 4'hF, rd);
         if (a != 16) `CHK(rd, m[a])
      end
      bus(1'b0, `LK_OFF_STATUS, '0, 4'hF, rd);
      `CHK(rd[1], 1'b0)
      for (int i = 0; i < 12; i++) begin
         bus(1'b1, wa[i], wd[i], i == 11 ? 4'h3 : 4'hF, rd);
         if (i != 11 && ok_wr(wa[i], wd[i], m[4])) m[wa[i]] = wd[i];
         bus(1'b0, wa[i], '0, 4'hF, rd);
         `CHK(rd, m[wa[i]])
      end
      run_int(0, 32'h0, 32'h1, 32'h0333_3333);
      run_int(1, 32'd90000, 32'h1, 32'h0333_3333);
      run_int(2, 32'h0, 32'h2, 32'h0333_3333);
      run_int(3, 32'h0, 32'h1, 32'h0666_6666);
      for (int i = 0; i < NS; i++) begin
         `CHK(near(xs[1][i], ys[0][i], d_tab[i]), 1'b1)
         `CHK(xs[2][i], xs[3][i])
         `CHK(ss[2][i], ss[0][i])
         if (ss[0][i] > 16'sh1000) `CHK(sy[0][i], 1'b1)
         if (ss[0][i] < -16'sh1000) `CHK(sy[0][i], 1'b0)
      end
      for (int t = 0; t < 3; t++) begin
         do_reset();
         bus(1'b1, `LK_OFF_FREQ, 32'h0041_8937, 4'hF, rd);
         bus(1'b1, `LK_OFF_CTRL, {29'h0, tm[t], 1'b1}, 4'hF, rd);
         bus(1'b0, `LK_OFF_STATUS, '0, 4'hF, rd);
         `CHK(rd[1], 1'b1)
         ref_en <= 1'b1;
         adc_en <= 1'b1;
         repeat (2) begin
            wait_edge(tm[t] == LK_TRIG_FALL);
            repeat (8) @(posedge clk);
            `CHK(sync, 1'b1)
            `CHK(sine >= 0 && sine < 16'sh0800, 1'b1)
            wait_edge(tm[t] != LK_TRIG_FALL);
            repeat (20) @(posedge clk);
            `CHK(sync, 1'b0)
         end
         bus(1'b0, `LK_OFF_STATUS, '0, 4'hF, rd);
         `CHK(rd[0], 1'b1)
         ref_en <= 1'b0;
         adc_en <= 1'b0;
      end
      wrap_up();
   end
endmodule
